// File: hdl/skip_table_pkg.sv
// constants and types shared by the skip and table-read executor
// Notes on behaviour
// - zero data byte skips next, flags untouched
// - taken skip adds one dummy cycle
// - no skip means no dummy slot
// - copy byte to accumulator, then zero-skip
// - skip when selected bit is clear
// - current page plus pointer, low byte stored
// - high part goes to table-high register
// - last-page variant uses final page
package skip_table_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int PC_W = 12;
    localparam int WORD_W = 15;
    localparam int HIGH_W = WORD_W - DATA_W;
    localparam int BIT_IDX_W = 3;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [HIGH_W-1:0] TABLE_HIGH_RESET = 7'h00;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_SKIP_IF_ZERO = 3'h1,
        OP_COPY_THEN_SKIP_IF_ZERO = 3'h2,
        OP_SKIP_IF_BIT_CLEAR = 3'h3,
        OP_TABLE_READ_CURRENT_PAGE = 3'h4,
        OP_TABLE_READ_LAST_PAGE = 3'h5
    } op_t;

    typedef enum logic [2:0] {
        ST_EXEC = 3'b001,
        ST_DUMMY = 3'b010,
        ST_TABLE_WAIT = 3'b100
    } state_t;
endpackage : skip_table_pkg

// File: hdl/skip_eval_if.sv
// interface carrying the skip decision between executor and evaluator
interface skip_eval_if;
    import skip_table_pkg::*;
    logic [DATA_W-1:0] operand;
    logic [BIT_IDX_W-1:0] bit_index;
    op_t op;
    logic skip;
    modport exec (output operand, output bit_index, output op, input skip);
    modport eval (input operand, input bit_index, input op, output skip);
endinterface : skip_eval_if

// File: hdl/skip_condition.sv
// combinational skip condition for the three test-and-skip instructions
module skip_condition
    import skip_table_pkg::*;
(
    skip_eval_if.eval bus
);
    wire byte_is_zero;
    wire bit_is_clear;
    assign byte_is_zero = (bus.operand == ZERO_BYTE);
    assign bit_is_clear = ~bus.operand[bus.bit_index];
    assign bus.skip = ((bus.op == OP_SKIP_IF_ZERO) && byte_is_zero)
                   || ((bus.op == OP_COPY_THEN_SKIP_IF_ZERO) && byte_is_zero)
                   || ((bus.op == OP_SKIP_IF_BIT_CLEAR) && bit_is_clear);
endmodule : skip_condition

// File: hdl/skip_and_table_read_exec.sv
// executor for skip and table-read instructions of the 8-bit core
module skip_and_table_read_exec
    import skip_table_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // decoded instruction
    input wire logic instr_valid,
    input wire op_t instr_op,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [BIT_IDX_W-1:0] bit_index,
    // data memory read port
    input wire logic [DATA_W-1:0] mem_rdata,
    // data memory write port
    output logic mem_we,
    output logic [ADDR_W-1:0] mem_waddr,
    output logic [DATA_W-1:0] mem_wdata,
    // program memory table port
    input wire logic [PC_W-1:0] pc,
    input wire logic [DATA_W-1:0] table_pointer_reg,
    output logic prog_re,
    output logic [PC_W-1:0] prog_addr,
    input wire logic [WORD_W-1:0] prog_word,
    // core results
    output logic [DATA_W-1:0] accumulator,
    output logic [HIGH_W-1:0] table_high_byte_reg,
    output logic squash,
    output logic busy,
    output logic done
);
    localparam int PAGE_W = PC_W - DATA_W;

    state_t state;
    state_t next_state;
    logic [ADDR_W-1:0] table_dest;
    skip_eval_if eval_bus ();

    skip_condition u_cond (.bus(eval_bus));

    assign eval_bus.operand = mem_rdata;
    assign eval_bus.bit_index = bit_index;
    assign eval_bus.op = instr_op;

    // decode of the one opcode that can be accepted this cycle
    wire in_exec;
    wire accept;
    wire op_zero;
    wire op_copy;
    wire op_bit;
    wire op_tab_cur;
    wire op_tab_last;
    wire is_skip_op;
    wire is_table_op;
    wire take_skip;
    wire start_table;
    wire table_finish;
    wire [PAGE_W-1:0] cur_page;
    wire [PAGE_W-1:0] last_page;
    wire [PAGE_W-1:0] page_sel;

    assign in_exec = (state == ST_EXEC);
    // anything offered while busy is dropped without notice; busy is the only sign
    assign accept = clk_en && in_exec && instr_valid;
    assign op_zero = (instr_op == OP_SKIP_IF_ZERO);
    assign op_copy = (instr_op == OP_COPY_THEN_SKIP_IF_ZERO);
    assign op_bit = (instr_op == OP_SKIP_IF_BIT_CLEAR);
    assign op_tab_cur = (instr_op == OP_TABLE_READ_CURRENT_PAGE);
    assign op_tab_last = (instr_op == OP_TABLE_READ_LAST_PAGE);
    assign is_skip_op = op_zero || op_copy || op_bit;
    assign is_table_op = op_tab_cur || op_tab_last;
    assign take_skip = accept && is_skip_op && eval_bus.skip;
    assign start_table = accept && is_table_op;
    // the wait state only ends on an enabled edge, so a freeze stretches it
    assign table_finish = clk_en && (state == ST_TABLE_WAIT);
    // last page is all ones in the page field
    assign cur_page = pc[PC_W-1:DATA_W];
    assign last_page = {PAGE_W{1'b1}};
    assign page_sel = op_tab_last ? last_page : cur_page;

    // next state: taken skip buys one dummy slot, untaken skip stays in exec
    always_comb begin
        next_state = state;
        unique case (state)
            ST_EXEC: begin
                if (take_skip) begin
                    next_state = ST_DUMMY;
                end else if (start_table) begin
                    next_state = ST_TABLE_WAIT;
                end else begin
                    next_state = ST_EXEC;
                end
            end
            ST_DUMMY: next_state = ST_EXEC;
            ST_TABLE_WAIT: next_state = ST_EXEC;
            default: next_state = ST_EXEC;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= ST_EXEC;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // next values of the registered outputs; every register below holds while clk_en is low
    wire next_prog_re;
    wire [PC_W-1:0] next_prog_addr;
    wire [ADDR_W-1:0] next_table_dest;
    wire [DATA_W-1:0] next_accumulator;
    wire next_mem_we;
    wire [ADDR_W-1:0] next_mem_waddr;
    wire [DATA_W-1:0] next_mem_wdata;
    wire [HIGH_W-1:0] next_table_high;
    wire [DATA_W-1:0] word_low;
    wire [HIGH_W-1:0] word_high;

    // program address is registered so the word arrives in the wait cycle
    assign next_prog_re = start_table;
    assign next_prog_addr = start_table ? {page_sel, table_pointer_reg} : prog_addr;
    assign next_table_dest = start_table ? mem_addr : table_dest;
    // the accumulator only moves for the copy variant; no flag output exists at all
    assign next_accumulator = (accept && op_copy) ? mem_rdata : accumulator;
    // low byte and high part come from one word and land on one edge
    assign word_low = prog_word[DATA_W-1:0];
    assign word_high = prog_word[WORD_W-1:DATA_W];
    assign next_mem_we = table_finish;
    assign next_mem_waddr = table_finish ? table_dest : mem_waddr;
    assign next_mem_wdata = table_finish ? word_low : mem_wdata;
    assign next_table_high = table_finish ? word_high : table_high_byte_reg;

    // read strobe is a pulse of one enabled cycle; it stays high while clk_en is low
    always_ff @(posedge clk) begin
        if (reset) begin
            prog_re <= 1'b0;
        end else if (clk_en) begin
            prog_re <= next_prog_re;
        end
    end

    // address stays put after the read for a slow program memory
    always_ff @(posedge clk) begin
        if (reset) begin
            prog_addr <= '0;
        end else if (clk_en) begin
            prog_addr <= next_prog_addr;
        end
    end

    // destination is kept because the decoded address may change in the wait cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            table_dest <= '0;
        end else if (clk_en) begin
            table_dest <= next_table_dest;
        end
    end

    // accumulator copy
    always_ff @(posedge clk) begin
        if (reset) begin
            accumulator <= ACC_RESET;
        end else if (clk_en) begin
            accumulator <= next_accumulator;
        end
    end

    // write strobe for the low byte
    always_ff @(posedge clk) begin
        if (reset) begin
            mem_we <= 1'b0;
        end else if (clk_en) begin
            mem_we <= next_mem_we;
        end
    end

    // write address
    always_ff @(posedge clk) begin
        if (reset) begin
            mem_waddr <= '0;
        end else if (clk_en) begin
            mem_waddr <= next_mem_waddr;
        end
    end

    // write data
    always_ff @(posedge clk) begin
        if (reset) begin
            mem_wdata <= ZERO_BYTE;
        end else if (clk_en) begin
            mem_wdata <= next_mem_wdata;
        end
    end

    // table-high register, written on the same edge as the low byte
    always_ff @(posedge clk) begin
        if (reset) begin
            table_high_byte_reg <= TABLE_HIGH_RESET;
        end else if (clk_en) begin
            table_high_byte_reg <= next_table_high;
        end
    end

    // completion: untaken skip at once, taken skip during its dummy slot, table read in the enabled cycle that ends its wait
    wire done_untaken;
    wire done_dummy;
    wire done_table;
    assign done_untaken = accept && is_skip_op && !take_skip;
    assign done_dummy = clk_en && (state == ST_DUMMY);
    assign done_table = table_finish;
    // the dummy slot: the core must drop whatever it fetched here
    assign squash = (state == ST_DUMMY);
    assign busy = !in_exec;
    assign done = done_untaken || done_dummy || done_table;
endmodule : skip_and_table_read_exec

// File: verif/skip_table_asserts.sv
// concurrent checks on the ports of the skip and table-read executor
module skip_table_asserts
    import skip_table_pkg::*;
(
    // watched ports
    input wire logic clk, reset, clk_en, instr_valid, prog_re, mem_we, squash, busy,
    input wire op_t instr_op,
    input wire logic [DATA_W-1:0] mem_rdata, table_pointer_reg, mem_wdata, accumulator,
    input wire logic [PC_W-1:0] pc, prog_addr,
    input wire logic [WORD_W-1:0] prog_word,
    input wire logic [BIT_IDX_W-1:0] bit_index,
    input wire logic [HIGH_W-1:0] table_high_byte_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // one-hot of the opcode accepted this cycle
    wire logic [7:0] hit = {7'h00, clk_en && instr_valid && !busy} << instr_op;
    wire logic bit_set = mem_rdata[bit_index];
    wire logic [PC_W-1:0] cur_addr = {pc[PC_W-1:8], table_pointer_reg};
    AST_ZERO_SKIP: assert property (hit[1] && mem_rdata == ZERO_BYTE |=> squash && busy)
        else $error("zero byte not skipped");
    AST_NO_SLOT: assert property ((hit[1] || hit[2]) && mem_rdata != ZERO_BYTE |=> !squash && !busy)
        else $error("slot without skip");
    AST_COPY: assert property (hit[2] |=> accumulator == $past(mem_rdata))
        else $error("copy lost");
    AST_BIT: assert property (hit[3] |=> squash == !$past(bit_set))
        else $error("bit test wrong");
    AST_CUR_PAGE: assert property (hit[4] |=> prog_re && prog_addr == $past(cur_addr))
        else $error("current page address");
    AST_LAST_PAGE: assert property (hit[5] |=> prog_re && prog_addr == {4'hF, $past(table_pointer_reg)})
        else $error("last page address");
    AST_WORD: assert property (prog_re && clk_en |=> mem_we && {table_high_byte_reg, mem_wdata} == $past(prog_word))
        else $error("table word split");
    AST_DISCARD: assert property (squash && clk_en |-> !mem_we && !prog_re ##1 !squash && $stable(accumulator))
        else $error("dummy cycle acted");
    AST_FREEZE: assert property (!clk_en |=> $stable(mem_we) && $stable(busy) && $stable(accumulator))
        else $error("state moved while frozen");
endmodule : skip_table_asserts
bind skip_and_table_read_exec skip_table_asserts chk_u (.*);

// File: verif/test_skip_and_table_read_exec.sv
// self-checking bench for the skip and table-read executor
module test_skip_and_table_read_exec
    import skip_table_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, clk_en = 1'b1;
    logic [14:0] words[$];
    logic prog_re, mem_we, squash, busy, done;
    op_t instr_op = OP_NONE;
    logic [7:0] mem_addr = 8'h00, mem_rdata = 8'h00, tp = 8'h00, mem_waddr, mem_wdata, accumulator;
    logic [2:0] bit_index = 3'h0;
    logic [11:0] pc = 12'h000, prog_addr;
    logic [14:0] prog_word = 15'h0000;
    logic [6:0] table_high_byte_reg;
    logic [15:0] s = 16'h6B7F;
    int n_errors = 0, compares = 0, acc = 0;
    always #20 clk = ~clk;
    skip_and_table_read_exec dut_u (.clk, .reset, .clk_en, .instr_valid, .instr_op, .mem_addr, .bit_index,
        .mem_rdata, .mem_we, .mem_waddr, .mem_wdata, .pc, .table_pointer_reg(tp), .prog_re, .prog_addr, .prog_word,
        .accumulator, .table_high_byte_reg, .squash, .busy, .done);
    function logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    task chk(input logic [14:0] seen, input logic [14:0] want);
        compares++;
        if (seen !== want) begin
            n_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : chk
    task complete_run;
        if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    task issue(input op_t o);
        logic [7:0] d;
        logic sk;
        logic frz;
        s = lfsr(lfsr(s));
        // some table reads get one frozen cycle in their wait state
        frz = s[0] && o > OP_SKIP_IF_BIT_CLEAR;
        // half of the operands are zero so both outcomes occur
        d = s[4] ? s[15:8] : 8'h00;
        sk = (o == OP_SKIP_IF_BIT_CLEAR) ? !d[s[7:5]] : (o < OP_SKIP_IF_BIT_CLEAR && d == 8'h00);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op <= o;
        mem_rdata <= d;
        mem_addr <= s[7:0];
        bit_index <= s[7:5];
        pc <= s[11:0];
        tp <= s[13:6];
        prog_word <= s[14:0];
        if (o > OP_SKIP_IF_BIT_CLEAR) words.push_back(s[14:0]);
        #1 chk(15'(done), 15'(o < OP_TABLE_READ_CURRENT_PAGE && !sk));
        @(posedge clk);
        // a taken skip is offered a junk copy in its dummy slot, which must leave no trace
        instr_valid <= sk;
        instr_op <= OP_COPY_THEN_SKIP_IF_ZERO;
        mem_rdata <= ~d;
        clk_en <= !frz;
        if (o == OP_COPY_THEN_SKIP_IF_ZERO) acc = d;
        #1 chk(15'({squash, busy, done}),
            15'({sk, sk || o > OP_SKIP_IF_BIT_CLEAR, sk || (o > OP_SKIP_IF_BIT_CLEAR && !frz)}));
        chk(15'(accumulator), 15'(acc));
        if (o > OP_SKIP_IF_BIT_CLEAR) begin
            chk(15'({prog_re, prog_addr}), 15'({1'b1, o == OP_TABLE_READ_LAST_PAGE ? 4'hF : s[11:8], s[13:6]}));
            if (frz) begin
                @(posedge clk);
                clk_en <= 1'b1;
                #1 chk(15'({mem_we, busy, done}), 15'h0003);
            end
            @(posedge clk);
            #1 chk({table_high_byte_reg, mem_wdata}, words.pop_front());
            chk(15'({mem_we, mem_waddr}), 15'({1'b1, s[7:0]}));
        end
    endtask : issue
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 300; i++) issue(op_t'(3'(i % 5 + 1)));
        complete_run();
    end
endmodule : test_skip_and_table_read_exec
